// ==== rtl/pbcbc_pkg.sv ====
// Purpose: shared constants, types and sensed-flag layout for the power bank controller
// Assumes: 100 MHz system clock, analogue comparators deliver flags
// Notes:   quantities are in mA, mV or mW, 16 bits wide
package pbcbc_pkg;

  localparam int CLK_PERIOD_NS            = 10;
  localparam int TICK_PERIOD_NS           = 1000000;
  localparam int TICK_CYC                 = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int TRICKLE_TIMEOUT_MIN      = 40;
  localparam int CONST_CURRENT_TIMEOUT_H  = 33;
  localparam int TRICKLE_TIMEOUT_TICKS    = TRICKLE_TIMEOUT_MIN * 60 * 1000;
  localparam int CONST_CURRENT_TIMEOUT_TICKS = CONST_CURRENT_TIMEOUT_H * 3600 * 1000;

  typedef logic [15:0] pbcbc_qty_t;

  localparam pbcbc_qty_t I_TRICKLE_LOW_MA  = 16'h00c8;
  localparam pbcbc_qty_t I_TRICKLE_HIGH_MA = 16'h012c;
  localparam pbcbc_qty_t I_FAST_5V_MA      = 16'h09c4;
  localparam pbcbc_qty_t I_FAST_HV_MA      = 16'h0fa0;
  localparam pbcbc_qty_t V_TARGET_FLOAT_MV = 16'h1068;
  localparam pbcbc_qty_t V_TARGET_R62K_MV  = 16'h10fe;
  localparam pbcbc_qty_t V_TARGET_R30K_MV  = 16'h1130;
  localparam pbcbc_qty_t V_TARGET_R10K_MV  = 16'h10cc;
  localparam pbcbc_qty_t BOOST_ILIM_LV_MA  = 16'h0bb8;
  localparam pbcbc_qty_t BOOST_ILIM_9V_MA  = 16'h07d0;
  localparam pbcbc_qty_t BOOST_ILIM_12V_MA = 16'h05dc;
  localparam pbcbc_qty_t BOOST_PLIM_MW     = 16'h4650;

  typedef enum logic [2:0] {
    PH_IDLE, PH_TRICKLE, PH_CONST_CURRENT, PH_CONST_VOLTAGE, PH_DONE, PH_TIMEOUT
  } pbcbc_phase_e;

  typedef enum logic [1:0] {STRAP_FLOAT, STRAP_R62K, STRAP_R30K, STRAP_R10K} pbcbc_strap_e;
  typedef enum logic [1:0] {LVL_GND, LVL_0V6, LVL_3V3, LVL_OTHER} pbcbc_lvl_e;
  typedef enum logic [1:0] {VREQ_5V, VREQ_9V, VREQ_12V, VREQ_STEP} pbcbc_vreq_e;

  typedef struct packed {
    logic       bat_below_1v5;
    logic       bat_below_3v;
    logic       bat_at_target;
    logic       bat_below_recharge;
    logic       chg_at_term;
    logic       temp_below_m15;
    logic       temp_below_0;
    logic       temp_below_5;
    logic       temp_above_10;
    logic       temp_above_45;
    logic       temp_above_50;
    logic       temp_above_58;
    logic       die_regu;
    logic       die_shutdown;
    logic       input_above_5v;
    logic       boost_heavy_load;
    logic       out_above_6v;
    logic       key_short;
    logic       load_insert;
    logic       a_light_load;
    logic       c_src_attach;
    logic       c_snk_attach;
    logic       c_snk_light;
    logic       microb_adapter;
    pbcbc_lvl_e dp_lvl;
    pbcbc_lvl_e dm_lvl;
  } pbcbc_sense_s;

endpackage : pbcbc_pkg

// ==== rtl/pbcbc_ctrl.sv ====
// Purpose: charger sequencing, protection, boost mode and port switching supervisor
// Assumes: every sense flag comes from an analogue comparator or detector, asynchronous
// Notes:   all sensed inputs pass a two-flop synchroniser before use
`timescale 1ns/1ps

//  Contract
// - trickle below 3V, constant current at 3V
// - trickle 200mA below 1.5V, else 300mA
// - at target voltage switch to constant voltage
// - termination current ends charge cycle
// - restart when battery under recharge threshold
// - strap selects 4.2/4.35/4.4/4.3V target
// - fast current 2.5A at 5V, 4A above
// - cold: half below 5C, stop below 0C
// - hot: half above 45C, stop above 50C
// - die regulation derates, shutdown powers device off
// - phase timeout latches off until re-insertion
// - pulse skip light load, fixed frequency heavy
// - boost 3A below 6V, 18W above
// - boost off outside -15..58C, restart by key/load
// - die regulation lowers vout, shutdown latches boost off
// - port A on key/load, off on light load
// - source attach enables port and charger
// - sink attach enables port and boost
// - micro-B adapter enables port and charger
// - fast negotiation only with one port active
// - advertise 3A sourcing, or micro-B without boost
// - DP/DM levels map to requested output voltage
// - trickle timeout is 40 minutes
// - constant current timeout is 33 hours
module pbcbc_ctrl #(
  parameter int TICK_CYC_P      = pbcbc_pkg::TICK_CYC,
  parameter int TRICKLE_TO_P    = pbcbc_pkg::TRICKLE_TIMEOUT_TICKS,
  parameter int CONST_CUR_TO_P  = pbcbc_pkg::CONST_CURRENT_TIMEOUT_TICKS
) (
  input  wire logic                  sys_clk_i,
  input  wire logic                  reset_i,
  input  wire pbcbc_pkg::pbcbc_sense_s sense_i,
  input  wire pbcbc_pkg::pbcbc_strap_e target_select_strap_i,
  output logic [2:0]                 charge_phase_o,
  output logic                       charger_en_o,
  output logic                       constant_voltage_phase_o,
  output logic                       charge_done_o,
  output logic                       charge_timeout_o,
  output pbcbc_pkg::pbcbc_qty_t      charge_current_ma_o,
  output pbcbc_pkg::pbcbc_qty_t      target_voltage_mv_o,
  output logic                       boost_en_o,
  output logic                       pulse_skip_mode_o,
  output logic                       boost_vout_reduce_o,
  output logic                       boost_power_cap_o,
  output pbcbc_pkg::pbcbc_qty_t      boost_ilim_ma_o,
  output pbcbc_pkg::pbcbc_qty_t      boost_plim_mw_o,
  output logic                       port_a_en_o,
  output logic                       port_c_en_o,
  output logic                       port_b_en_o,
  output logic                       fast_allow_o,
  output logic                       c_adv_3a_o,
  output pbcbc_pkg::pbcbc_vreq_e     vout_request_o,
  output logic                       power_off_o
);

  function automatic pbcbc_pkg::pbcbc_qty_t halve(input pbcbc_pkg::pbcbc_qty_t q);
    halve = {1'b0, q[15:1]};
  endfunction : halve

  pbcbc_pkg::pbcbc_sense_s sense_m_r;
  pbcbc_pkg::pbcbc_sense_s s;
  pbcbc_pkg::pbcbc_strap_e strap_m_r;
  pbcbc_pkg::pbcbc_strap_e strap_s_r;
  pbcbc_pkg::pbcbc_phase_e phase_r;
  pbcbc_pkg::pbcbc_phase_e phase_nxt;
  pbcbc_pkg::pbcbc_qty_t   target_mv_r;
  pbcbc_pkg::pbcbc_qty_t   ichg_nxt;
  pbcbc_pkg::pbcbc_vreq_e  vreq_r;
  logic        strap_done_r;
  logic [31:0] tick_cnt_r;
  logic        tick_r;
  logic [31:0] phase_ms_r;
  logic        to_lock_r;
  logic        cold_half_r;
  logic        cold_stop_r;
  logic        hot_half_r;
  logic        hot_stop_r;
  logic        shutdown_r;
  logic        boost_lock_r;
  logic        port_a_r;
  logic        snk_on_r;
  logic        snk_prev_r;
  logic        src_present;
  logic        chg_hold;
  logic        boost_fault;
  logic        boost_on;
  logic        fast_allow;
  logic [1:0]  active_ports;

  // only the second stage is read; pins may change at any time
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      sense_m_r <= '0;
      s         <= '0;
      strap_m_r <= pbcbc_pkg::STRAP_FLOAT;
      strap_s_r <= pbcbc_pkg::STRAP_FLOAT;
    end else begin
      sense_m_r <= sense_i;
      s         <= sense_m_r;
      strap_m_r <= target_select_strap_i;
      strap_s_r <= strap_m_r;
    end
  end

  // strap is caught once after reset, the pin later doubles as an led drive
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      strap_done_r <= 1'b0;
      target_mv_r  <= pbcbc_pkg::V_TARGET_FLOAT_MV;
    end else if (!strap_done_r && phase_r == pbcbc_pkg::PH_IDLE && tick_cnt_r == 32'd2) begin
      strap_done_r <= 1'b1;
      unique case (strap_s_r)
        pbcbc_pkg::STRAP_FLOAT: target_mv_r <= pbcbc_pkg::V_TARGET_FLOAT_MV;
        pbcbc_pkg::STRAP_R62K:  target_mv_r <= pbcbc_pkg::V_TARGET_R62K_MV;
        pbcbc_pkg::STRAP_R30K:  target_mv_r <= pbcbc_pkg::V_TARGET_R30K_MV;
        pbcbc_pkg::STRAP_R10K:  target_mv_r <= pbcbc_pkg::V_TARGET_R10K_MV;
      endcase
    end
  end

  // 1 ms enable for the phase timers
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      tick_cnt_r <= '0;
      tick_r     <= 1'b0;
    end else begin
      tick_r     <= (tick_cnt_r == 32'(TICK_CYC_P - 1));
      tick_cnt_r <= (tick_cnt_r == 32'(TICK_CYC_P - 1)) ? '0 : tick_cnt_r + 32'd1;
    end
  end

  // port switching
  assign src_present = s.c_src_attach | s.microb_adapter;
  assign active_ports = 2'(port_a_r) + 2'(s.c_src_attach | snk_on_r) + 2'(s.microb_adapter);
  assign fast_allow = (active_ports <= 2'd1);

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      port_a_r <= 1'b0;
    end else if (s.key_short || s.load_insert) begin
      port_a_r <= 1'b1;
    end else if (s.a_light_load || boost_fault || shutdown_r) begin
      port_a_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      snk_on_r   <= 1'b0;
      snk_prev_r <= 1'b0;
    end else begin
      snk_prev_r <= s.c_snk_attach;
      if (!s.c_snk_attach || s.c_snk_light || boost_fault || shutdown_r) begin
        snk_on_r <= 1'b0;
      end else if ((!snk_prev_r) || s.load_insert || s.key_short) begin
        snk_on_r <= 1'b1;
      end
    end
  end

  // battery temperature windows for the charger, with rewarm hysteresis
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      cold_half_r <= 1'b0;
      cold_stop_r <= 1'b0;
    end else begin
      if (s.temp_below_0) begin
        cold_stop_r <= 1'b1;
      end else if (!s.temp_below_5) begin
        cold_stop_r <= 1'b0;
      end
      if (s.temp_below_5) begin
        cold_half_r <= 1'b1;
      end else if (s.temp_above_10) begin
        cold_half_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      hot_half_r <= 1'b0;
      hot_stop_r <= 1'b0;
    end else begin
      hot_half_r <= s.temp_above_45;
      hot_stop_r <= s.temp_above_50;
    end
  end

  // die shutdown powers the device off until the next reset, except port C while a source is attached
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      shutdown_r <= 1'b0;
    end else if (s.die_shutdown) begin
      shutdown_r <= 1'b1;
    end
  end

  assign chg_hold = cold_stop_r | hot_stop_r | shutdown_r;

  // charger phase sequencing
  always_comb begin
    phase_nxt = phase_r;
    unique case (phase_r)
      pbcbc_pkg::PH_IDLE:
        if (src_present && !to_lock_r) phase_nxt = pbcbc_pkg::PH_TRICKLE;
      pbcbc_pkg::PH_TRICKLE:
        if (phase_ms_r >= 32'(TRICKLE_TO_P)) phase_nxt = pbcbc_pkg::PH_TIMEOUT;
        else if (!s.bat_below_3v) phase_nxt = pbcbc_pkg::PH_CONST_CURRENT;
      pbcbc_pkg::PH_CONST_CURRENT:
        if (phase_ms_r >= 32'(CONST_CUR_TO_P)) phase_nxt = pbcbc_pkg::PH_TIMEOUT;
        else if (s.bat_at_target) phase_nxt = pbcbc_pkg::PH_CONST_VOLTAGE;
      pbcbc_pkg::PH_CONST_VOLTAGE:
        if (s.chg_at_term) phase_nxt = pbcbc_pkg::PH_DONE;
      pbcbc_pkg::PH_DONE:
        if (s.bat_below_recharge) phase_nxt = pbcbc_pkg::PH_TRICKLE;
      pbcbc_pkg::PH_TIMEOUT:
        phase_nxt = pbcbc_pkg::PH_TIMEOUT;
      default:
        phase_nxt = pbcbc_pkg::PH_IDLE;
    endcase
    if (!src_present || shutdown_r) phase_nxt = pbcbc_pkg::PH_IDLE;
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      phase_r <= pbcbc_pkg::PH_IDLE;
    end else begin
      phase_r <= phase_nxt;
    end
  end

  // timer pauses while temperature holds the charger off
  always_ff @(posedge sys_clk_i) begin
    if (reset_i || phase_nxt != phase_r) begin
      phase_ms_r <= '0;
    end else if (tick_r && !chg_hold && phase_ms_r != '1) begin
      phase_ms_r <= phase_ms_r + 32'd1;
    end
  end

  // the lock only clears once every adapter is gone, i.e. on re-insertion
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      to_lock_r <= 1'b0;
    end else if (phase_nxt == pbcbc_pkg::PH_TIMEOUT) begin
      to_lock_r <= 1'b1;
    end else if (!src_present) begin
      to_lock_r <= 1'b0;
    end
  end

  // requested charge current
  always_comb begin
    ichg_nxt = (s.input_above_5v && fast_allow) ? pbcbc_pkg::I_FAST_HV_MA
                                                : pbcbc_pkg::I_FAST_5V_MA;
    if (phase_r == pbcbc_pkg::PH_TRICKLE) begin
      ichg_nxt = s.bat_below_1v5 ? pbcbc_pkg::I_TRICKLE_LOW_MA
                                 : pbcbc_pkg::I_TRICKLE_HIGH_MA;
    end
    if (cold_half_r || hot_half_r) ichg_nxt = halve(ichg_nxt);
    if (s.die_regu) ichg_nxt = halve(ichg_nxt);
    if (chg_hold || phase_r == pbcbc_pkg::PH_IDLE || phase_r == pbcbc_pkg::PH_DONE ||
        phase_r == pbcbc_pkg::PH_TIMEOUT) ichg_nxt = '0;
  end

  // boost protection latches; key or load re-arms, a standing fault sets again
  assign boost_fault = s.temp_below_m15 | s.temp_above_58 | s.die_shutdown;

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      boost_lock_r <= 1'b0;
    end else if (boost_fault) begin
      boost_lock_r <= 1'b1;
    end else if (s.key_short || s.load_insert) begin
      boost_lock_r <= 1'b0;
    end
  end

  assign boost_on = (port_a_r | snk_on_r) & ~boost_lock_r & ~shutdown_r;

  // legacy high-voltage request decoder
  always_ff @(posedge sys_clk_i) begin
    if (reset_i || !fast_allow) begin
      vreq_r <= pbcbc_pkg::VREQ_5V;
    end else if (s.dp_lvl == pbcbc_pkg::LVL_0V6 && s.dm_lvl == pbcbc_pkg::LVL_GND) begin
      vreq_r <= pbcbc_pkg::VREQ_5V;
    end else if (s.dp_lvl == pbcbc_pkg::LVL_3V3 && s.dm_lvl == pbcbc_pkg::LVL_0V6) begin
      vreq_r <= pbcbc_pkg::VREQ_9V;
    end else if (s.dp_lvl == pbcbc_pkg::LVL_0V6 && s.dm_lvl == pbcbc_pkg::LVL_0V6) begin
      vreq_r <= pbcbc_pkg::VREQ_12V;
    end else if (s.dp_lvl == pbcbc_pkg::LVL_0V6 && s.dm_lvl == pbcbc_pkg::LVL_3V3) begin
      vreq_r <= pbcbc_pkg::VREQ_STEP;
    end
  end

  // registered outputs
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      charge_phase_o           <= 3'(pbcbc_pkg::PH_IDLE);
      charger_en_o             <= 1'b0;
      constant_voltage_phase_o <= 1'b0;
      charge_done_o            <= 1'b0;
      charge_timeout_o         <= 1'b0;
      charge_current_ma_o      <= '0;
      boost_en_o               <= 1'b0;
      pulse_skip_mode_o        <= 1'b0;
      boost_vout_reduce_o      <= 1'b0;
      boost_power_cap_o        <= 1'b0;
      boost_ilim_ma_o          <= '0;
      boost_plim_mw_o          <= '0;
      port_a_en_o              <= 1'b0;
      port_c_en_o              <= 1'b0;
      port_b_en_o              <= 1'b0;
      fast_allow_o             <= 1'b0;
      c_adv_3a_o               <= 1'b0;
      power_off_o              <= 1'b0;
    end else begin
      charge_phase_o           <= 3'(phase_r);
      charger_en_o             <= (ichg_nxt != '0);
      constant_voltage_phase_o <= (phase_r == pbcbc_pkg::PH_CONST_VOLTAGE);
      charge_done_o            <= (phase_r == pbcbc_pkg::PH_DONE);
      charge_timeout_o         <= to_lock_r;
      charge_current_ma_o      <= ichg_nxt;
      boost_en_o               <= boost_on;
      pulse_skip_mode_o        <= boost_on & ~s.boost_heavy_load;
      boost_vout_reduce_o      <= boost_on & s.die_regu;
      boost_power_cap_o        <= boost_on & s.out_above_6v;
      boost_plim_mw_o          <= s.out_above_6v ? pbcbc_pkg::BOOST_PLIM_MW : '0;
      if (!s.out_above_6v) begin
        boost_ilim_ma_o <= pbcbc_pkg::BOOST_ILIM_LV_MA;
      end else if (vreq_r == pbcbc_pkg::VREQ_9V) begin
        boost_ilim_ma_o <= pbcbc_pkg::BOOST_ILIM_9V_MA;
      end else begin
        boost_ilim_ma_o <= pbcbc_pkg::BOOST_ILIM_12V_MA;
      end
      port_a_en_o              <= port_a_r & boost_on;
      port_c_en_o              <= s.c_src_attach | (snk_on_r & boost_on);
      port_b_en_o              <= s.microb_adapter & ~shutdown_r;
      fast_allow_o             <= fast_allow;
      c_adv_3a_o               <= (snk_on_r & boost_on) | (s.microb_adapter & ~boost_on);
      power_off_o              <= shutdown_r;
    end
  end

  assign vout_request_o = vreq_r;
  assign target_voltage_mv_o = target_mv_r;

  // checks
  property p_trickle_exit;
    @(posedge sys_clk_i) disable iff (reset_i)
      (phase_r == pbcbc_pkg::PH_TRICKLE && !s.bat_below_3v && src_present && !shutdown_r &&
       phase_ms_r < 32'(TRICKLE_TO_P)) |=> phase_r == pbcbc_pkg::PH_CONST_CURRENT;
  endproperty
  a_trickle_exit: assert property (p_trickle_exit) else $error("trickle did not exit at 3V");

  property p_trickle_low;
    @(posedge sys_clk_i) disable iff (reset_i)
      (phase_r == pbcbc_pkg::PH_TRICKLE && s.bat_below_1v5 && !chg_hold && !cold_half_r &&
       !hot_half_r && !s.die_regu) |=> charge_current_ma_o == pbcbc_pkg::I_TRICKLE_LOW_MA;
  endproperty
  a_trickle_low: assert property (p_trickle_low) else $error("trickle low current wrong");

  property p_term;
    @(posedge sys_clk_i) disable iff (reset_i)
      (phase_r == pbcbc_pkg::PH_CONST_VOLTAGE && s.chg_at_term && src_present && !shutdown_r)
      |=> ##1 charge_done_o && charge_current_ma_o == '0;
  endproperty
  a_term: assert property (p_term) else $error("termination did not finish charge");

  property p_recharge;
    @(posedge sys_clk_i) disable iff (reset_i)
      (phase_r == pbcbc_pkg::PH_DONE && s.bat_below_recharge && src_present && !shutdown_r)
      |=> phase_r == pbcbc_pkg::PH_TRICKLE;
  endproperty
  a_recharge: assert property (p_recharge) else $error("no automatic recharge");

  property p_strap;
    @(posedge sys_clk_i) disable iff (reset_i)
      $rose(strap_done_r) && $past(strap_s_r) == pbcbc_pkg::STRAP_R30K
      |-> target_voltage_mv_o == pbcbc_pkg::V_TARGET_R30K_MV;
  endproperty
  a_strap: assert property (p_strap) else $error("strap decode wrong");

  property p_fast_cur;
    @(posedge sys_clk_i) disable iff (reset_i)
      (phase_r == pbcbc_pkg::PH_CONST_CURRENT && !chg_hold && !cold_half_r && !hot_half_r &&
       !s.die_regu) |=> charge_current_ma_o ==
       ($past(s.input_above_5v && fast_allow) ? pbcbc_pkg::I_FAST_HV_MA
                                             : pbcbc_pkg::I_FAST_5V_MA);
  endproperty
  a_fast_cur: assert property (p_fast_cur) else $error("fast charge current wrong");

  property p_cold_stop;
    @(posedge sys_clk_i) disable iff (reset_i)
      s.temp_below_0 |=> ##1 charge_current_ma_o == '0 && !charger_en_o;
  endproperty
  a_cold_stop: assert property (p_cold_stop) else $error("charger ran below 0C");

  property p_hot_stop;
    @(posedge sys_clk_i) disable iff (reset_i)
      s.temp_above_50 [*2] |=> !charger_en_o;
  endproperty
  a_hot_stop: assert property (p_hot_stop) else $error("charger ran above 50C");

  property p_boost_temp;
    @(posedge sys_clk_i) disable iff (reset_i)
      (s.temp_below_m15 || s.temp_above_58) |=> ##1 !boost_en_o;
  endproperty
  a_boost_temp: assert property (p_boost_temp) else $error("boost on outside range");

  property p_port_a_light;
    @(posedge sys_clk_i) disable iff (reset_i)
      (s.a_light_load && !s.key_short && !s.load_insert) |=> ##1 !port_a_en_o;
  endproperty
  a_port_a_light: assert property (p_port_a_light) else $error("port A stayed on");

  property p_fast_limit;
    @(posedge sys_clk_i) disable iff (reset_i)
      (active_ports >= 2'd2) |=> vout_request_o == pbcbc_pkg::VREQ_5V && !fast_allow_o;
  endproperty
  a_fast_limit: assert property (p_fast_limit) else $error("fast mode with many ports");

  property p_hold_prev;
    @(posedge sys_clk_i) disable iff (reset_i)
      (fast_allow && s.dp_lvl == pbcbc_pkg::LVL_3V3 && s.dm_lvl == pbcbc_pkg::LVL_3V3)
      |=> $stable(vout_request_o);
  endproperty
  a_hold_prev: assert property (p_hold_prev) else $error("3.3V/3.3V changed output");

endmodule : pbcbc_ctrl

// ==== sim/pbcbc_far_model.sv ====
// Purpose: far side of the ports, an adapter or a powered device on each port
// Assumes: attach and DP/DM levels are held by the bench as levels
// Notes:   DLY_P stages make the far side answer slowly, like a debounced plug
`timescale 1ns/1ps
module pbcbc_far_model #(
  parameter int DLY_P = 3
) (
  input  wire logic       sys_clk_i,
  input  wire logic [6:0] cmd_i,
  output logic      [6:0] line_o
);
  // bit 6 source, 5 sink, 4 micro-b adapter, 3:2 dp level, 1:0 dm level
  logic [6:0] pipe_r [DLY_P];
  always_ff @(posedge sys_clk_i) begin
    pipe_r[0] <= cmd_i;
    for (int i = 1; i < DLY_P; i++) begin
      pipe_r[i] <= pipe_r[i-1];
    end
  end
  assign line_o = pipe_r[DLY_P-1];
endmodule : pbcbc_far_model

// ==== sim/power_bank_charge_boost_control_bench.sv ====
// Purpose: self-checking bench for the power bank supervisor
// Assumes: shortened tick and timeout counts, sense flags driven as levels
// Notes:   results settle within six edges of a flag change
`timescale 1ns/1ps
module power_bank_charge_boost_control_bench;
  localparam int          TKC    = 4;
  localparam int          TTO    = 20;
  localparam int          CCT    = 30;
  localparam logic [5:0]  TF [9] = '{6'h20, 6'h30, 6'h20, 6'h00, 6'h08, 6'h0c, 6'h0e, 6'h09, 6'h08};
  localparam logic [15:0] TC [9] = '{16'h04e2, 16'h0, 16'h0, 16'h04e2, 16'h09c4, 16'h04e2,
                                     16'h0, 16'h04e2, 16'h09c4};
  localparam logic [3:0]  LV [5] = '{4'h4, 4'h9, 4'h5, 4'h6, 4'ha};
  logic                    sys_clk_i = 1'b0;
  logic                    reset_i = 1'b1;
  pbcbc_pkg::pbcbc_sense_s s, sense_w;
  pbcbc_pkg::pbcbc_strap_e strap;
  pbcbc_pkg::pbcbc_qty_t   cur, tgt, ilim, plim;
  pbcbc_pkg::pbcbc_vreq_e  vreq;
  logic [6:0]              cmd, line;
  logic [3:0]              lv;
  logic [1:0]              vq;
  logic [2:0]              phase;
  logic                    chg, cv, done, tmo, ben, pulse_skip_mode, vred, pcap, pa, pc, pb, fast, adv, poff;
  int                      err_count = 0;
  int                      n_compared = 0;
  int                      seed = 6;
  int                      n;

  always #5 sys_clk_i = ~sys_clk_i;

  always_comb begin
    sense_w = s;
    {sense_w.c_src_attach, sense_w.c_snk_attach, sense_w.microb_adapter} = line[6:4];
    sense_w.dp_lvl = pbcbc_pkg::pbcbc_lvl_e'(line[3:2]);
    sense_w.dm_lvl = pbcbc_pkg::pbcbc_lvl_e'(line[1:0]);
  end

  pbcbc_far_model #(.DLY_P(3)) u_pbcbc_far_model (.sys_clk_i(sys_clk_i), .cmd_i(cmd), .line_o(line));
  pbcbc_ctrl #(.TICK_CYC_P(TKC), .TRICKLE_TO_P(TTO), .CONST_CUR_TO_P(CCT)) u_pbcbc_ctrl (
    .sys_clk_i(sys_clk_i), .reset_i(reset_i), .sense_i(sense_w), .target_select_strap_i(strap),
    .charge_phase_o(phase), .charger_en_o(chg), .constant_voltage_phase_o(cv),
    .charge_done_o(done), .charge_timeout_o(tmo), .charge_current_ma_o(cur),
    .target_voltage_mv_o(tgt), .boost_en_o(ben), .pulse_skip_mode_o(pulse_skip_mode),
    .boost_vout_reduce_o(vred), .boost_power_cap_o(pcap), .boost_ilim_ma_o(ilim),
    .boost_plim_mw_o(plim), .port_a_en_o(pa), .port_c_en_o(pc), .port_b_en_o(pb),
    .fast_allow_o(fast), .c_adv_3a_o(adv), .vout_request_o(vreq), .power_off_o(poff));

  function automatic logic [15:0] tgt_exp(input int k);
    logic [15:0] t [4] = '{16'h1068, 16'h10fe, 16'h1130, 16'h10cc};
    return t[k];
  endfunction : tgt_exp

  // unlisted levels and 3.3/3.3 keep the previous request
  function automatic logic [1:0] vq_exp(input logic [3:0] l, input logic [1:0] prev);
    case (l)
      4'h4: return 2'h0;
      4'h9: return 2'h1;
      4'h5: return 2'h2;
      4'h6: return 2'h3;
      default: return prev;
    endcase
  endfunction : vq_exp

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic step;
    @(posedge sys_clk_i);
  endtask : step

  // sample one time unit after the edge so register updates have landed
  task automatic settle(input int k);
    repeat (k) @(posedge sys_clk_i);
    #1;
  endtask : settle

  task automatic pulse(input logic [1:0] w);
    step();
    {s.key_short, s.a_light_load} <= w;
    step();
    {s.key_short, s.a_light_load} <= 2'h0;
    settle(6);
  endtask : pulse

  task automatic end_of_test;
    if (err_count == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_of_test

  initial begin
    s = '0;
    s.temp_above_10 = 1'b1;
    cmd = 7'h0;
    strap = pbcbc_pkg::STRAP_FLOAT;
    for (int k = 0; k < 4; k++) begin
      step();
      reset_i <= 1'b1;
      strap <= pbcbc_pkg::pbcbc_strap_e'(k);
      repeat (16) step();
      reset_i <= 1'b0;
      settle(1);
      chk("idle", 16'({chg, pc, ben, pa, pb, poff, phase}), 16'h0);
      settle(6);
      chk("target", tgt, tgt_exp(k));
    end
    step();
    {s.bat_below_3v, s.bat_below_1v5} <= 2'h3;
    cmd <= 7'h40;
    settle(10);
    chk("phase", 16'(phase), 16'h1);
    chk("cur", cur, 16'h00c8);
    chk("port_c", 16'(pc), 16'h1);
    step();
    s.bat_below_1v5 <= 1'b0;
    settle(6);
    chk("cur", cur, 16'h012c);
    step();
    s.bat_below_3v <= 1'b0;
    settle(6);
    chk("phase", 16'(phase), 16'h2);
    chk("cur", cur, 16'h09c4);
    step();
    s.input_above_5v <= 1'b1;
    settle(6);
    chk("cur", cur, 16'h0fa0);
    chk("fast", 16'(fast), 16'h1);
    for (int i = 0; i < 9; i++) begin
      step();
      {s.input_above_5v, s.temp_below_5, s.temp_below_0, s.temp_above_10, s.temp_above_45,
       s.temp_above_50, s.die_regu} <= {1'b0, TF[i]};
      settle(6);
      chk("temp_cur", cur, TC[i]);
    end
    step();
    s.bat_at_target <= 1'b1;
    settle(6);
    chk("cv", 16'(cv), 16'h1);
    step();
    s.chg_at_term <= 1'b1;
    settle(6);
    chk("done", 16'(done), 16'h1);
    chk("done_cur", cur, 16'h0);
    step();
    {s.bat_at_target, s.chg_at_term, s.bat_below_recharge} <= 3'h1;
    settle(8);
    chk("recharge", 16'(chg), 16'h1);
    step();
    {s.bat_below_recharge, s.bat_below_3v} <= 2'h1;
    cmd <= 7'h0;
    settle(10);
    step();
    cmd <= 7'h40;
    n = 0;
    while (tmo !== 1'b1 && n < 300) begin
      settle(1);
      n++;
    end
    chk("tmo_at", 16'(n >= TKC * (TTO - 1) && n <= TKC * TTO + 20), 16'h1);
    if (n >= 300) end_of_test();
    settle(2);
    chk("tmo_chg", 16'(chg), 16'h0);
    step();
    cmd <= 7'h0;
    s.bat_below_3v <= 1'b0;
    settle(10);
    step();
    cmd <= 7'h40;
    settle(10);
    chk("reinsert", 16'(chg), 16'h1);
    n = 0;
    while (tmo !== 1'b1 && n < 300) begin
      settle(1);
      n++;
    end
    chk("cc_tmo_at", 16'(n >= TKC * (CCT - 2) && n <= TKC * CCT + 20), 16'h1);
    if (n >= 300) end_of_test();
    step();
    cmd <= 7'h20;
    settle(10);
    chk("src_off", 16'(chg), 16'h0);
    chk("sink", 16'({ben, pc, adv, pulse_skip_mode}), 16'hf);
    chk("ilim", ilim, 16'h0bb8);
    step();
    {s.boost_heavy_load, s.out_above_6v, s.die_regu} <= 3'h7;
    settle(6);
    chk("heavy", 16'({pulse_skip_mode, pcap, vred}), 16'h3);
    chk("plim", plim, 16'h4650);
    step();
    {s.boost_heavy_load, s.out_above_6v, s.die_regu, s.temp_above_58} <= 4'h1;
    settle(6);
    chk("hot58", 16'(ben), 16'h0);
    step();
    s.temp_above_58 <= 1'b0;
    settle(6);
    chk("cooled", 16'(ben), 16'h0);
    pulse(2'h2);
    chk("key", 16'({ben, pa, fast}), 16'h6);
    pulse(2'h1);
    chk("a_light", 16'(pa), 16'h0);
    step();
    s.c_snk_light <= 1'b1;
    settle(6);
    chk("c_light", 16'(pc), 16'h0);
    step();
    s.c_snk_light <= 1'b0;
    cmd <= 7'h0;
    settle(10);
    pulse(2'h2);
    vq = 2'h0;
    for (int i = 0; i < 14; i++) begin
      lv = (i < 5) ? LV[i] : 4'($random(seed));
      step();
      cmd <= {3'h0, lv};
      s.out_above_6v <= 1'b1;
      settle(8);
      vq = vq_exp(lv, vq);
      chk("vreq", 16'(vreq), 16'(vq));
      chk("ilim_hv", ilim, (vq == 2'h1) ? 16'h07d0 : 16'h05dc);
    end
    pulse(2'h1);
    step();
    cmd <= 7'h10;
    settle(10);
    chk("micro_b", 16'({pb, chg, adv}), 16'h7);
    step();
    s.die_shutdown <= 1'b1;
    settle(6);
    chk("shutdown", 16'({poff, chg}), 16'h2);
    end_of_test();
  end
endmodule : power_bank_charge_boost_control_bench
